//--- logic/pqs_pkg.sv
package pqs_pkg;

	localparam int P_WIDTH = 6;
	localparam int Q_WIDTH = 7;
	localparam int S_WIDTH = 8;

	localparam int         IDX_WIDTH = 4;
	localparam logic [3:0] REG_COUNT = 4'hC;
	localparam logic [3:0] REG_P_DRIVE     = 4'h0;
	localparam logic [3:0] REG_P_PULL_EN   = 4'h1;
	localparam logic [3:0] REG_P_PULL_SEL  = 4'h2;
	localparam logic [3:0] REG_Q_DATA      = 4'h3;
	localparam logic [3:0] REG_Q_LEVEL     = 4'h4;
	localparam logic [3:0] REG_Q_DIR       = 4'h5;
	localparam logic [3:0] REG_Q_DRIVE     = 4'h6;
	localparam logic [3:0] REG_Q_PULL_EN   = 4'h7;
	localparam logic [3:0] REG_Q_PULL_SEL  = 4'h8;
	localparam logic [3:0] REG_S_DATA      = 4'h9;
	localparam logic [3:0] REG_S_LEVEL     = 4'hA;
	localparam logic [3:0] REG_S_DIR       = 4'hB;

	localparam logic [5:0] RST_P = 6'h00;
	localparam logic [6:0] RST_Q = 7'h00;
	localparam logic [7:0] RST_S = 8'h00;

	localparam int FAULT_LO  = 0;
	localparam int FAULT_W   = 4;
	localparam int SENSE_LO  = 4;
	localparam int SENSE_W   = 3;
	localparam int SPI_LO    = 4;
	localparam int SPI_W     = 4;
	localparam int TX2_BIT   = 3;
	localparam int RX2_BIT   = 2;
	localparam int TX1_BIT   = 1;
	localparam int RX1_BIT   = 0;

	typedef struct packed {
		logic out;
		logic oe;
		logic reduced;
		logic pull_en;
		logic pull_down;
	} pqs_pad_t;

	typedef struct packed {
		logic                 en;
		logic [IDX_WIDTH-1:0] idx;
		logic [31:0]          data;
	} pqs_wr_t;

endpackage

//--- logic/pqs_pin_cell.sv
`timescale 1ns/10ps
module pqs_pin_cell
	import pqs_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] drive,
	input  wire logic [WIDTH-1:0] pull_en,
	input  wire logic [WIDTH-1:0] pull_sel,
	input  wire logic [WIDTH-1:0] own,
	input  wire logic [WIDTH-1:0] own_oe,
	input  wire logic [WIDTH-1:0] own_out,
	output pqs_pad_t  [WIDTH-1:0] pad
);
	logic [WIDTH-1:0] oe_next;

	if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
		$error("pqs_pin_cell: WIDTH must be 1 to 8");
	end

	// Owner picks direction; stored bits stay untouched underneath
	assign oe_next = (own & own_oe) | (~own & dir);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pad <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < WIDTH; i++) begin
				pad[i].oe        <= oe_next[i];
				pad[i].out       <= own[i] ? own_out[i] : data[i];
				pad[i].reduced   <= drive[i] & oe_next[i];
				pad[i].pull_en   <= pull_en[i] & ~oe_next[i];
				pad[i].pull_down <= pull_sel[i];
			end
		end
	end

endmodule

//--- logic/pqs_ahb_slave.sv
`timescale 1ns/10ps
module pqs_ahb_slave
	import pqs_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic      [IDX_WIDTH-1:0] rd_idx,
	input  wire logic [31:0]          rd_word,
	output pqs_wr_t                   wr
);
	logic                 go;
	logic                 hit;
	logic                 wr_pend_reg;
	logic [IDX_WIDTH-1:0] wr_idx_reg;

	// Only whole-word transfers exist; hsize is accepted as given
	assign go     = hsel & hready & htrans[1];
	assign rd_idx = haddr[IDX_WIDTH+1:2];
	assign hit    = (haddr[31:IDX_WIDTH+2] == '0) && (haddr[1:0] == 2'h0)
	                && (rd_idx < REG_COUNT);

	assign wr.en   = wr_pend_reg;
	assign wr.idx  = wr_idx_reg;
	assign wr.data = hwdata;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			// Unmapped reads return zero with an OKAY answer
			hrdata <= (go && !hwrite && hit) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= '0;
		end else if (clk_en) begin
			wr_pend_reg <= go & hwrite & hit;
			wr_idx_reg  <= rd_idx;
		end
	end

	// Zero wait states, never an error
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule

//--- logic/pqs_top.sv
`timescale 1ns/10ps
module pqs_top
	import pqs_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire logic               clk_en,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [P_WIDTH-1:0] pulse_modulator_chan_en,
	input  wire logic [P_WIDTH-1:0] pulse_modulator_out,
	input  wire logic [FAULT_W-1:0] pulse_modulator_fault_en,
	input  wire logic [SENSE_W-1:0] modulator_current_sense_en,
	output logic      [FAULT_W-1:0] pulse_modulator_fault_in,
	output logic      [SENSE_W-1:0] modulator_current_sense_in,
	input  wire logic               spi_en,
	input  wire logic [SPI_W-1:0]   spi_oe,
	input  wire logic [SPI_W-1:0]   spi_out,
	output logic      [SPI_W-1:0]   spi_in,
	input  wire logic               second_async_serial_tx_en,
	input  wire logic               second_async_serial_rx_en,
	input  wire logic               second_serial_transmit,
	output logic                    second_serial_receive,
	input  wire logic               first_async_serial_tx_en,
	input  wire logic               first_async_serial_rx_en,
	input  wire logic               first_serial_transmit,
	output logic                    first_serial_receive,
	output pqs_pad_t  [P_WIDTH-1:0] port_p_pad,
	input  wire logic [Q_WIDTH-1:0] fault_port_pin_in,
	output pqs_pad_t  [Q_WIDTH-1:0] fault_port_pad,
	input  wire logic [S_WIDTH-1:0] serial_port_pin_in,
	output pqs_pad_t  [S_WIDTH-1:0] serial_port_pad
);
	logic [P_WIDTH-1:0] port_p_drive_strength_reg;
	logic [P_WIDTH-1:0] port_p_pull_enable_reg;
	logic [P_WIDTH-1:0] port_p_pull_select_reg;
	logic [Q_WIDTH-1:0] fault_port_data_reg;
	logic [Q_WIDTH-1:0] fault_port_direction_reg;
	logic [Q_WIDTH-1:0] fault_port_drive_strength_reg;
	logic [Q_WIDTH-1:0] fault_port_pull_enable_reg;
	logic [Q_WIDTH-1:0] fault_port_pull_select_reg;
	logic [S_WIDTH-1:0] serial_port_data_reg;
	logic [S_WIDTH-1:0] serial_port_direction_reg;

	pqs_wr_t            wr;
	logic [IDX_WIDTH-1:0] rd_idx;
	logic [31:0]        rd_word;
	logic [Q_WIDTH-1:0] q_own;
	logic [S_WIDTH-1:0] s_own;
	logic [S_WIDTH-1:0] s_own_oe;
	logic [S_WIDTH-1:0] s_own_out;
	logic [Q_WIDTH-1:0] q_oe;
	logic [Q_WIDTH-1:0] q_red;
	logic [Q_WIDTH-1:0] q_pe;
	logic [Q_WIDTH-1:0] q_pd;
	logic [S_WIDTH-1:0] s_oe;
	logic [S_WIDTH-1:0] s_out;
	logic [P_WIDTH-1:0] p_oe;
	logic [P_WIDTH-1:0] p_out;

	pqs_ahb_slave u_bus (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd_idx    (rd_idx),
		.rd_word   (rd_word),
		.wr        (wr)
	);

	// Pin level reads bypass any register, so they track the pads
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			REG_P_DRIVE:    rd_word[P_WIDTH-1:0] = port_p_drive_strength_reg;
			REG_P_PULL_EN:  rd_word[P_WIDTH-1:0] = port_p_pull_enable_reg;
			REG_P_PULL_SEL: rd_word[P_WIDTH-1:0] = port_p_pull_select_reg;
			REG_Q_DATA: begin
				rd_word[Q_WIDTH-1:0] =
					(fault_port_direction_reg & fault_port_data_reg)
					| (~fault_port_direction_reg & fault_port_pin_in);
			end
			REG_Q_LEVEL:    rd_word[Q_WIDTH-1:0] = fault_port_pin_in;
			REG_Q_DIR:      rd_word[Q_WIDTH-1:0] = fault_port_direction_reg;
			REG_Q_DRIVE:    rd_word[Q_WIDTH-1:0] = fault_port_drive_strength_reg;
			REG_Q_PULL_EN:  rd_word[Q_WIDTH-1:0] = fault_port_pull_enable_reg;
			REG_Q_PULL_SEL: rd_word[Q_WIDTH-1:0] = fault_port_pull_select_reg;
			REG_S_DATA: begin
				rd_word[S_WIDTH-1:0] =
					(serial_port_direction_reg & serial_port_data_reg)
					| (~serial_port_direction_reg & serial_port_pin_in);
			end
			REG_S_LEVEL:    rd_word[S_WIDTH-1:0] = serial_port_pin_in;
			REG_S_DIR:      rd_word[S_WIDTH-1:0] = serial_port_direction_reg;
			default:        rd_word = 32'h0000_0000;
		endcase
	end

	// Only bus writes touch these; level registers have no storage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			port_p_drive_strength_reg <= RST_P;
			port_p_pull_enable_reg    <= RST_P;
			port_p_pull_select_reg    <= RST_P;
		end else if (clk_en && wr.en) begin
			case (wr.idx)
				REG_P_DRIVE:    port_p_drive_strength_reg <= wr.data[P_WIDTH-1:0];
				REG_P_PULL_EN:  port_p_pull_enable_reg    <= wr.data[P_WIDTH-1:0];
				REG_P_PULL_SEL: port_p_pull_select_reg    <= wr.data[P_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fault_port_data_reg           <= RST_Q;
			fault_port_direction_reg      <= RST_Q;
			fault_port_drive_strength_reg <= RST_Q;
			fault_port_pull_enable_reg    <= RST_Q;
			fault_port_pull_select_reg    <= RST_Q;
		end else if (clk_en && wr.en) begin
			case (wr.idx)
				REG_Q_DATA:     fault_port_data_reg <= wr.data[Q_WIDTH-1:0];
				REG_Q_DIR:      fault_port_direction_reg <= wr.data[Q_WIDTH-1:0];
				REG_Q_DRIVE:    fault_port_drive_strength_reg <= wr.data[Q_WIDTH-1:0];
				REG_Q_PULL_EN:  fault_port_pull_enable_reg <= wr.data[Q_WIDTH-1:0];
				REG_Q_PULL_SEL: fault_port_pull_select_reg <= wr.data[Q_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			serial_port_data_reg      <= RST_S;
			serial_port_direction_reg <= RST_S;
		end else if (clk_en && wr.en) begin
			case (wr.idx)
				REG_S_DATA: serial_port_data_reg      <= wr.data[S_WIDTH-1:0];
				REG_S_DIR:  serial_port_direction_reg <= wr.data[S_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// Fault port owners only ever force inputs
	assign q_own = {modulator_current_sense_en, pulse_modulator_fault_en};

	always_comb begin
		s_own     = '0;
		s_own_oe  = '0;
		s_own_out = '0;
		s_own[SPI_LO +: SPI_W]     = {SPI_W{spi_en}};
		s_own_oe[SPI_LO +: SPI_W]  = spi_oe;
		s_own_out[SPI_LO +: SPI_W] = spi_out;
		s_own[TX2_BIT]     = second_async_serial_tx_en;
		s_own_oe[TX2_BIT]  = 1'b1;
		s_own_out[TX2_BIT] = second_serial_transmit;
		s_own[RX2_BIT]     = second_async_serial_rx_en;
		s_own[TX1_BIT]     = first_async_serial_tx_en;
		s_own_oe[TX1_BIT]  = 1'b1;
		s_own_out[TX1_BIT] = first_serial_transmit;
		s_own[RX1_BIT]     = first_async_serial_rx_en;
	end

	// Port P has no direction register here; idle pins stay inputs
	pqs_pin_cell #(.WIDTH(P_WIDTH)) u_port_p (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.dir      ('0),
		.data     ('0),
		.drive    (port_p_drive_strength_reg),
		.pull_en  (port_p_pull_enable_reg),
		.pull_sel (port_p_pull_select_reg),
		.own      (pulse_modulator_chan_en),
		.own_oe   ({P_WIDTH{1'b1}}),
		.own_out  (pulse_modulator_out),
		.pad      (port_p_pad)
	);

	pqs_pin_cell #(.WIDTH(Q_WIDTH)) u_port_q (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.dir      (fault_port_direction_reg),
		.data     (fault_port_data_reg),
		.drive    (fault_port_drive_strength_reg),
		.pull_en  (fault_port_pull_enable_reg),
		.pull_sel (fault_port_pull_select_reg),
		.own      (q_own),
		.own_oe   ('0),
		.own_out  ('0),
		.pad      (fault_port_pad)
	);

	// Serial port drive and pull controls lie outside this block
	pqs_pin_cell #(.WIDTH(S_WIDTH)) u_port_s (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.dir      (serial_port_direction_reg),
		.data     (serial_port_data_reg),
		.drive    ('0),
		.pull_en  ('0),
		.pull_sel ('0),
		.own      (s_own),
		.own_oe   (s_own_oe),
		.own_out  (s_own_out),
		.pad      (serial_port_pad)
	);

	// Pin levels go to peripherals through one flop, like the pads
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pulse_modulator_fault_in   <= '0;
			modulator_current_sense_in <= '0;
			spi_in                     <= '0;
			second_serial_receive      <= 1'b0;
			first_serial_receive       <= 1'b0;
		end else if (clk_en) begin
			pulse_modulator_fault_in <= fault_port_pin_in[FAULT_LO +: FAULT_W];
			modulator_current_sense_in <= fault_port_pin_in[SENSE_LO +: SENSE_W];
			spi_in                <= serial_port_pin_in[SPI_LO +: SPI_W];
			second_serial_receive <= serial_port_pin_in[RX2_BIT];
			first_serial_receive  <= serial_port_pin_in[RX1_BIT];
		end
	end

	always_comb begin
		for (int i = 0; i < Q_WIDTH; i++) begin
			q_oe[i]  = fault_port_pad[i].oe;
			q_red[i] = fault_port_pad[i].reduced;
			q_pe[i]  = fault_port_pad[i].pull_en;
			q_pd[i]  = fault_port_pad[i].pull_down;
		end
		for (int i = 0; i < S_WIDTH; i++) begin
			s_oe[i]  = serial_port_pad[i].oe;
			s_out[i] = serial_port_pad[i].out;
		end
		for (int i = 0; i < P_WIDTH; i++) begin
			p_oe[i]  = port_p_pad[i].oe;
			p_out[i] = port_p_pad[i].out;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	logic rd_go;
	assign rd_go = hsel & hready & htrans[1] & ~hwrite & clk_en;

	// On the release edge the pads are still reset but peripheral
	// enables are not, so that attempt must not check the override
	logic run;
	assign run = clk_en & ~sys_rst;

	AST_DRIVE_INPUT: assert property (
		clk_en |=> q_red == ($past(fault_port_drive_strength_reg) & q_oe))
		else $error("reduced drive on an input pin");

	AST_PULL_INPUT: assert property (
		clk_en |=> q_pe == ($past(fault_port_pull_enable_reg) & ~q_oe))
		else $error("pull enable wrong for pin direction");

	AST_PULL_POLARITY: assert property (
		clk_en |=> (q_pd & q_pe) == ($past(fault_port_pull_select_reg) & q_pe))
		else $error("pull polarity differs from select");

	AST_FAULT_OWNED_INPUT: assert property (
		clk_en && (q_own != '0) |=> (q_oe & $past(q_own)) == '0)
		else $error("owned fault pin is driving");

	AST_FAULT_ROUTE: assert property (
		run |=> pulse_modulator_fault_in == $past(fault_port_pin_in[3:0])
		&& modulator_current_sense_in == $past(fault_port_pin_in[6:4]))
		else $error("fault pin routing mismatch");

	AST_RESET_INPUT: assert property (
		@(posedge core_clk) disable iff (1'b0)
		sys_rst |=> q_oe == '0 && s_oe == '0)
		else $error("pin driven after reset edge");

	AST_DATA_READ: assert property (
		rd_go && haddr == {26'h0, REG_Q_DATA, 2'h0} |=>
		hrdata[Q_WIDTH-1:0] == (($past(fault_port_direction_reg)
		& $past(fault_port_data_reg)) | (~$past(fault_port_direction_reg)
		& $past(fault_port_pin_in))))
		else $error("fault data read mixes wrong source");

	AST_LEVEL_READ: assert property (
		rd_go && haddr == {26'h0, REG_S_LEVEL, 2'h0} |=>
		hrdata == {24'h0, $past(serial_port_pin_in)})
		else $error("serial level read not the pins");

	AST_FAULT_DIR: assert property (
		clk_en && q_own == '0 |=> q_oe == $past(fault_port_direction_reg))
		else $error("free fault pin ignores direction");

	AST_SPI_OWN: assert property (
		run && spi_en |=> s_oe[7:4] == $past(spi_oe)
		&& s_out[7:4] == $past(spi_out))
		else $error("SPI pins not under SPI control");

	AST_TX_OWN: assert property (
		run && second_async_serial_tx_en && first_async_serial_tx_en |=>
		s_oe[3] && s_oe[1] && s_out[3] == $past(second_serial_transmit)
		&& s_out[1] == $past(first_serial_transmit))
		else $error("transmit pin not driven by serial");

	AST_RX_OWN: assert property (
		clk_en && second_async_serial_rx_en && first_async_serial_rx_en |=>
		!s_oe[2] && !s_oe[0])
		else $error("receive pin driven");

	AST_SERIAL_FREE: assert property (
		clk_en && s_own == '0 |=> s_oe == $past(serial_port_direction_reg)
		&& s_out == $past(serial_port_data_reg))
		else $error("free serial pins ignore registers");

	AST_CHAN_OUT: assert property (
		run |=> p_oe == $past(pulse_modulator_chan_en)
		&& (p_out & p_oe) == ($past(pulse_modulator_out) & p_oe))
		else $error("modulator channel pin direction wrong");

	AST_REG_KEEP: assert property (
		!(clk_en && wr.en) |=> $stable(fault_port_direction_reg)
		&& $stable(serial_port_direction_reg) && $stable(fault_port_data_reg))
		else $error("stored register changed without write");

	COV_SPI_ON: cover property (clk_en && spi_en ##1 clk_en && !spi_en);
	COV_FAULT_OWN: cover property (clk_en && q_own != '0 && q_oe == '0);
	COV_DATA_READ: cover property (rd_go && rd_idx == REG_Q_DATA);
	COV_WRITE_DIR: cover property (wr.en && wr.idx == REG_S_DIR);

endmodule

//--- testbench/pqs_pin_model.sv
`timescale 1ns/10ps
module pqs_pin_model
	import pqs_pkg::*;
(
	input  wire pqs_pad_t [Q_WIDTH-1:0] fault_port_pad,
	input  wire pqs_pad_t [S_WIDTH-1:0] serial_port_pad,
	input  wire logic     [Q_WIDTH-1:0] ext_q,
	input  wire logic     [S_WIDTH-1:0] ext_s,
	output logic          [Q_WIDTH-1:0] fault_port_pin_in,
	output logic          [S_WIDTH-1:0] serial_port_pin_in
);
	// Board drivers are weak: a pad that drives always sets the level
	always_comb begin
		for (int i = 0; i < Q_WIDTH; i++) begin
			fault_port_pin_in[i] = fault_port_pad[i].oe ?
				fault_port_pad[i].out : ext_q[i];
		end
		for (int i = 0; i < S_WIDTH; i++) begin
			serial_port_pin_in[i] = serial_port_pad[i].oe ?
				serial_port_pad[i].out : ext_s[i];
		end
	end
endmodule

//--- testbench/tb_port_pqs_pin_integration.sv
`timescale 1ns/10ps
module tb_port_pqs_pin_integration
	import pqs_pkg::*;
;
	logic                 core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	logic [31:0]          haddr = 0, hwdata = 0, hrdata;
	logic [1:0]           htrans = 0;
	logic [2:0]           hsize = 0, chk = 0;
	logic                 hreadyout, hresp, spi_en = 0, ce = 1;
	logic [5:0]           pm_en = 0, pm_out = 0, pdrv, ppe, pps;
	logic [3:0]           f_en = 0, spi_oe = 0, spi_out = 0, f_in, spi_in;
	logic [2:0]           c_en = 0, c_in;
	logic                 tx2 = 0, rx2 = 0, tx1 = 0, rx1 = 0;
	logic                 tx2d = 0, tx1d = 0, rx2d, rx1d;
	logic [6:0]           qdat, qdir, qdrv, qpe, qps, q_oe, q_out, lq;
	logic [7:0]           sdat, sdir, s_oe, s_out, ls;
	logic [6:0]           ext_q = 0, pin_q;
	logic [7:0]           ext_s = 0, pin_s;
	pqs_pad_t [5:0]       pp;
	pqs_pad_t [6:0]       qpad;
	pqs_pad_t [7:0]       spad;
	logic [39:0]          notes[$], e, sn;
	logic [63:0]          v;
	bit                   ok;
	int                   n_mismatch = 0, tests_run = 0;
	string nm[6] = '{"", "hrdata", "port_p_pad", "fault_port_pad",
		"serial_port_pad", "peripheral_in"};

	always #2.5 core_clk = ~core_clk;
	assign lq = (q_oe & q_out) | (~q_oe & ext_q);
	assign ls = (s_oe & s_out) | (~s_oe & ext_s);

	pqs_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pulse_modulator_chan_en(pm_en), .pulse_modulator_out(pm_out),
		.pulse_modulator_fault_en(f_en), .modulator_current_sense_en(c_en),
		.pulse_modulator_fault_in(f_in), .modulator_current_sense_in(c_in),
		.spi_en(spi_en), .spi_oe(spi_oe), .spi_out(spi_out), .spi_in(spi_in),
		.second_async_serial_tx_en(tx2), .second_async_serial_rx_en(rx2),
		.second_serial_transmit(tx2d), .second_serial_receive(rx2d),
		.first_async_serial_tx_en(tx1), .first_async_serial_rx_en(rx1),
		.first_serial_transmit(tx1d), .first_serial_receive(rx1d),
		.port_p_pad(pp), .fault_port_pin_in(pin_q), .fault_port_pad(qpad),
		.serial_port_pin_in(pin_s), .serial_port_pad(spad));

	pqs_pin_model u_pins (.fault_port_pad(qpad), .serial_port_pad(spad),
		.ext_q(ext_q), .ext_s(ext_s), .fault_port_pin_in(pin_q),
		.serial_port_pin_in(pin_s));

	function automatic bit padok(pqs_pad_t s, pqs_pad_t x);
		// Drive strength and pull sense only matter where they take effect
		return s.oe === x.oe && s.pull_en === x.pull_en &&
			(!x.oe || (s.out === x.out && s.reduced === x.reduced)) &&
			(!x.pull_en || s.pull_down === x.pull_down);
	endfunction

	function automatic logic [39:0] exp_p();
		pqs_pad_t [5:0] r;
		for (int i = 0; i < 6; i++) begin
			r[i] = '{pm_out[i], pm_en[i], pdrv[i], ppe[i] & ~pm_en[i], pps[i]};
		end
		return 40'(r);
	endfunction

	function automatic logic [39:0] exp_q();
		pqs_pad_t [6:0] r;
		q_oe = qdir & ~{c_en, f_en};
		q_out = qdat;
		for (int i = 0; i < 7; i++) begin
			r[i] = '{qdat[i], q_oe[i], qdrv[i], qpe[i] & ~q_oe[i], qps[i]};
		end
		return 40'(r);
	endfunction

	function automatic logic [39:0] exp_s();
		pqs_pad_t [7:0] r;
		s_oe = sdir;
		s_out = sdat;
		if (spi_en) begin
			s_oe[7:4] = spi_oe;
			s_out[7:4] = spi_out;
		end
		if (tx2) {s_oe[3], s_out[3]} = {1'b1, tx2d};
		if (rx2) s_oe[2] = 1'b0;
		if (tx1) {s_oe[1], s_out[1]} = {1'b1, tx1d};
		if (rx1) s_oe[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			r[i] = '{s_out[i], s_oe[i], 1'b0, 1'b0, 1'b0};
		end
		return 40'(r);
	endfunction

	function automatic logic [31:0] rexp(input logic [3:0] i);
		case (i)
			REG_P_DRIVE:    return 32'(pdrv);
			REG_P_PULL_EN:  return 32'(ppe);
			REG_P_PULL_SEL: return 32'(pps);
			REG_Q_DATA:     return 32'((qdat & qdir) | (lq & ~qdir));
			REG_Q_LEVEL:    return 32'(lq);
			REG_Q_DIR:      return 32'(qdir);
			REG_Q_DRIVE:    return 32'(qdrv);
			REG_Q_PULL_EN:  return 32'(qpe);
			REG_Q_PULL_SEL: return 32'(qps);
			REG_S_DATA:     return 32'((sdat & sdir) | (ls & ~sdir));
			REG_S_LEVEL:    return 32'(ls);
			default:        return 32'(sdir);
		endcase
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic waitr();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] hreadyout expected 1 seen %b", hreadyout);
			report_and_stop();
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge core_clk);
		{hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, 2'h2, w, 3'h2};
		waitr();
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) chk <= 3'h1;
		waitr();
		chk <= 3'h0;
	endtask

	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		bus(1'b1, {26'h0, i, 2'h0}, d);
		case (i)
			REG_P_DRIVE:    pdrv = d[5:0];
			REG_P_PULL_EN:  ppe = d[5:0];
			REG_P_PULL_SEL: pps = d[5:0];
			REG_Q_DATA:     qdat = d[6:0];
			REG_Q_DIR:      qdir = d[6:0];
			REG_Q_DRIVE:    qdrv = d[6:0];
			REG_Q_PULL_EN:  qpe = d[6:0];
			REG_Q_PULL_SEL: qps = d[6:0];
			REG_S_DATA:     sdat = d[7:0];
			REG_S_DIR:      sdir = d[7:0];
			default:        ;
		endcase
	endtask

	task automatic rd(input logic [31:0] a, x);
		notes.push_back({8'h0, x});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic pk(input logic [2:0] k, input logic [39:0] x);
		notes.push_back(x);
		@(posedge core_clk);
		chk <= k;
		@(posedge core_clk);
		chk <= 3'h0;
	endtask

	task automatic check_all();
		repeat (3) @(posedge core_clk);
		pk(3'h2, exp_p());
		pk(3'h3, exp_q());
		pk(3'h4, exp_s());
		pk(3'h5, 40'({lq[3:0], lq[6:4], ls[7:4], ls[2], ls[0]}));
		for (int i = 0; i < 12; i++) rd(32'(i * 4), rexp(4'(i)));
		rd(32'h30, 32'h0);
	endtask

	always @(posedge core_clk) begin
		if (chk != 3'h0) begin
			e = notes.size() > 0 ? notes.pop_front() : 'x;
			ok = 1'b1;
			case (chk)
				3'h1:    sn = {7'h0, hresp, hrdata};
				3'h2:    sn = 40'(pp);
				3'h3:    sn = 40'(qpad);
				3'h4:    sn = 40'(spad);
				default: sn = 40'({f_in, c_in, spi_in, rx2d, rx1d});
			endcase
			if (chk == 3'h1 || chk == 3'h5) begin
				ok = sn === e;
			end else begin
				for (int i = 0; i < 8; i++) begin
					if (i < 4 + int'(chk)) ok = ok & padok(sn[i*5+:5], e[i*5+:5]);
				end
			end
			tests_run++;
			if (!ok) begin
				n_mismatch++;
				$display("[ERR] %s expected %h seen %h", nm[chk], e, sn);
			end
		end
	end

	initial begin
		{pdrv, ppe, pps, qdat, qdir, qdrv, qpe, qps, sdat, sdir} = '0;
		v = {$urandom(19), 32'h0};
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		check_all();
		$display("test reset_defaults done");
		for (int it = 0; it < 24; it++) begin
			v = {$urandom(), $urandom()};
			// Every fourth pass hands all pins back to the registers
			if (it % 4 == 0) v[33:16] = '0;
			@(posedge core_clk);
			{pm_en, f_en, c_en, spi_en, tx2, rx2, tx1, rx1} <= v[33:16];
			{pm_out, spi_oe, spi_out, tx2d, tx1d} <= v[15:0];
			{ext_q, ext_s} <= 15'($urandom());
			for (int i = 0; i < 12; i++) wr(4'(i), $urandom());
			bus(1'b1, 32'h30, $urandom());
			check_all();
		end
		$display("test random_config done");
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		pk(3'h3, 40'h0);
		pk(3'h4, 40'h0);
		{pdrv, ppe, pps, qdat, qdir, qdrv, qpe, qps, sdat, sdir} = '0;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		{pm_en, f_en, c_en, spi_en, tx2, rx2, tx1, rx1} <= '0;
		check_all();
		$display("test mid_reset done");
		// A frozen block must not pick up a new channel enable
		@(posedge core_clk);
		ce <= 1'b0;
		pm_en <= 6'h3F;
		repeat (3) @(posedge core_clk);
		pk(3'h2, 40'h0);
		ce <= 1'b1;
		repeat (3) @(posedge core_clk);
		pk(3'h2, exp_p());
		$display("test clock_freeze done");
		report_and_stop();
	end
endmodule
